//--- core/cardbus_status_change_regs.sv
// Contract
// - four status-change registers at 80h, 84h, 88h, 8Ch, memory space only
// - decoder claims memory cycles only; I/O cycles are answered but never reach them
// - event bit 4 sets on any detected wake-up event
// - event bit 4 clears when the pm event status flag is cleared
// - event bit 15 sets while interrupt pending; write 1 or reset clears
// - status change pin asserts only with mask bits 4 and 14 set
// - mask bits 4 and 14 clear on power-up reset
// - mask bit 15 gates the interrupt pin; clears on hw/sw reset
// - present bit 4 shows wake state; clears with event or flag
// - present bit 15 shows internal interrupt; clears with its cause
// - force write 1 sets event bit 4 or 15, present untouched
`timescale 1ns/100ps
`default_nettype none

module cardbus_status_change_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_reset_req,
    input wire logic sw_reset_req,
    input wire logic req_valid,
    input wire logic req_mem_space,
    input wire logic req_write,
    input wire logic [cardbus_status_pkg::ADDR_W-1:0] req_addr,
    input wire logic [cardbus_status_pkg::DATA_W-1:0] req_wdata,
    input wire logic [3:0] req_byte_en,
    output logic rsp_valid,
    output logic rsp_claim,
    output logic [cardbus_status_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic wake_event_pin,
    input wire logic pm_event_detect,
    input wire logic pm_event_status_flag,
    input wire logic pm_event_enable_flag,
    input wire logic func_int_pending,
    output logic status_change_pin,
    output logic int_pin
);
    import cardbus_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic fn_reset;
    logic wake_pin_rise;
    logic wake_seen;
    logic pm_status_prev_reg;
    logic pm_status_cleared;
    logic addr_mapped;
    logic hit;
    logic wr_event;
    logic wr_mask;
    logic wr_force;
    logic clr_wake;
    logic clr_int;
    logic force_wake;
    logic force_int;

    pin_event_sync wake_sync (
        .clk(clk),
        .rst(rst),
        .pin_async(wake_event_pin),
        .rise_pulse(wake_pin_rise)
    );

    always_comb begin
        fn_reset = hw_reset_req | sw_reset_req;
        wake_seen = pm_event_detect | wake_pin_rise;
        pm_status_cleared = pm_status_prev_reg & ~pm_event_status_flag;
        addr_mapped = (req_addr == OFS_EVENT) || (req_addr == OFS_MASK) ||
            (req_addr == OFS_PRESENT) || (req_addr == OFS_FORCE);
        hit = req_valid & req_mem_space & addr_mapped;
        wr_event = hit & req_write & (req_addr == OFS_EVENT);
        wr_mask = hit & req_write & (req_addr == OFS_MASK);
        wr_force = hit & req_write & (req_addr == OFS_FORCE);
        clr_wake = wr_event & req_byte_en[LANE_WAKE] & req_wdata[BIT_WAKE];
        clr_int = wr_event & req_byte_en[LANE_HIGH] & req_wdata[BIT_INT];
        force_wake = wr_force & req_byte_en[LANE_WAKE] &
            req_wdata[BIT_WAKE];
        force_int = wr_force & req_byte_en[LANE_HIGH] &
            req_wdata[BIT_INT];
    end

    ////////////////////////////////////////////////////////////////////////
    // event, mask and present state

    logic event_wake_reg;
    logic event_wake_next;
    logic event_int_reg;
    logic event_int_next;
    logic mask_wake_reg;
    logic mask_wake_next;
    logic mask_summary_reg;
    logic mask_summary_next;
    logic mask_int_reg;
    logic mask_int_next;
    logic present_wake_reg;
    logic present_wake_next;
    logic present_int_reg;
    logic present_int_next;

    always_comb begin
        // set beats clear so a wake-up in the clearing cycle is kept;
        // hw and sw resets deliberately leave this bit alone
        event_wake_next = event_wake_reg;
        if (wake_seen || force_wake) begin
            event_wake_next = 1'b1;
        end else if (clr_wake || pm_status_cleared) begin
            event_wake_next = 1'b0;
        end

        event_int_next = event_int_reg;
        if (fn_reset) begin
            event_int_next = 1'b0;
        end else if (func_int_pending || force_int) begin
            event_int_next = 1'b1;
        end else if (clr_int) begin
            event_int_next = 1'b0;
        end

        // wake and summary enables survive hw and sw reset
        mask_wake_next = mask_wake_reg;
        mask_summary_next = mask_summary_reg;
        if (wr_mask && req_byte_en[LANE_WAKE]) begin
            mask_wake_next = req_wdata[BIT_WAKE];
        end
        if (wr_mask && req_byte_en[LANE_HIGH]) begin
            mask_summary_next = req_wdata[BIT_SUMMARY];
        end

        mask_int_next = mask_int_reg;
        if (fn_reset) begin
            mask_int_next = 1'b0;
        end else if (wr_mask && req_byte_en[LANE_HIGH]) begin
            mask_int_next = req_wdata[BIT_INT];
        end

        present_wake_next = present_wake_reg;
        if (fn_reset) begin
            present_wake_next = 1'b0;
        end else if (wake_seen) begin
            present_wake_next = 1'b1;
        end else if (clr_wake || pm_status_cleared) begin
            present_wake_next = 1'b0;
        end

        // cause goes away when masked or acknowledged upstream
        present_int_next = fn_reset ? 1'b0 : func_int_pending;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_wake_reg <= RST_BIT;
            event_int_reg <= RST_BIT;
            mask_wake_reg <= RST_BIT;
            mask_summary_reg <= RST_BIT;
            mask_int_reg <= RST_BIT;
            present_wake_reg <= RST_BIT;
            present_int_reg <= RST_BIT;
            pm_status_prev_reg <= RST_BIT;
        end else begin
            event_wake_reg <= event_wake_next;
            event_int_reg <= event_int_next;
            mask_wake_reg <= mask_wake_next;
            mask_summary_reg <= mask_summary_next;
            mask_int_reg <= mask_int_next;
            present_wake_reg <= present_wake_next;
            present_int_reg <= present_int_next;
            pm_status_prev_reg <= pm_event_status_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path and pins

    logic [DATA_W-1:0] rdata_next;
    logic rsp_valid_next;
    logic rsp_claim_next;
    logic stschg_next;
    logic int_pin_next;

    always_comb begin
        rdata_next = RST_WORD;
        if (hit && !req_write) begin
            case (req_addr)
                OFS_EVENT: begin
                    rdata_next[BIT_WAKE] = event_wake_reg;
                    rdata_next[BIT_INT] = event_int_reg;
                end
                OFS_MASK: begin
                    rdata_next[BIT_WAKE] = mask_wake_reg;
                    rdata_next[BIT_SUMMARY] = mask_summary_reg;
                    rdata_next[BIT_INT] = mask_int_reg;
                end
                OFS_PRESENT: begin
                    rdata_next[BIT_WAKE] = present_wake_reg;
                    rdata_next[BIT_INT] = present_int_reg;
                end
                default: begin
                    rdata_next = RST_WORD;
                end
            endcase
        end
        // every request is answered; only memory hits are claimed
        rsp_valid_next = req_valid;
        rsp_claim_next = hit;
        // enable flag is the host's own gate on the pin
        stschg_next = event_wake_reg & mask_wake_reg & mask_summary_reg &
            pm_event_enable_flag;
        int_pin_next = event_int_reg & mask_int_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= RST_BIT;
            rsp_claim <= RST_BIT;
            rsp_rdata <= RST_WORD;
            status_change_pin <= RST_BIT;
            int_pin <= RST_BIT;
        end else begin
            rsp_valid <= rsp_valid_next;
            rsp_claim <= rsp_claim_next;
            rsp_rdata <= rdata_next;
            status_change_pin <= stschg_next;
            int_pin <= int_pin_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence seq_force_wake_only;
        force_wake && !wake_seen && !present_wake_reg;
    endsequence

    sequence seq_event_set_present_clear;
        event_wake_reg && !present_wake_reg;
    endsequence

    chk_mem_claim: assert property (
        req_valid && req_mem_space && req_addr == OFS_PRESENT
        |=> rsp_valid && rsp_claim)
        else $error("memory hit not claimed");

    chk_io_ignored: assert property (
        req_valid && !req_mem_space |=> rsp_valid && !rsp_claim &&
        rsp_rdata == RST_WORD)
        else $error("io cycle reached status registers");

    chk_wake_latch: assert property (
        wake_seen && !fn_reset |=> event_wake_reg && present_wake_reg ##1
        (event_wake_reg || $past(clr_wake) || $past(pm_status_cleared)))
        else $error("wake-up event not latched");

    chk_wake_survives: assert property (
        fn_reset && event_wake_reg && !clr_wake && !pm_status_cleared
        |=> event_wake_reg)
        else $error("wake event lost on function reset");

    chk_pm_clear: assert property (
        pm_event_status_flag ##1 !pm_event_status_flag && !wake_seen &&
        !force_wake |=> !event_wake_reg && !present_wake_reg)
        else $error("wake event kept after status flag clear");

    chk_int_latch: assert property (
        func_int_pending && !fn_reset |=> event_int_reg && present_int_reg)
        else $error("pending interrupt not latched");

    chk_stschg_gate: assert property (
        status_change_pin |-> $past(mask_wake_reg) &&
        $past(mask_summary_reg) && $past(event_wake_reg))
        else $error("status change pin without both enables");

    chk_mask_keep: assert property (
        fn_reset && mask_summary_reg && !wr_mask |=> mask_summary_reg)
        else $error("summary enable lost on function reset");

    chk_int_pin: assert property (
        event_int_reg && mask_int_reg |=> int_pin)
        else $error("interrupt pin not following enable");

    chk_int_gate: assert property (
        int_pin |-> $past(mask_int_reg) && $past(event_int_reg))
        else $error("interrupt pin without its enable");

    chk_fn_reset: assert property (
        fn_reset |=> !present_wake_reg && !present_int_reg &&
        !mask_int_reg && !event_int_reg)
        else $error("function reset did not clear state");

    chk_force_event: assert property (
        seq_force_wake_only |=> seq_event_set_present_clear)
        else $error("force write touched present state");

endmodule

`default_nettype wire

//--- core/cardbus_status_pkg.sv
package cardbus_status_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets in memory space
    localparam logic [7:0] OFS_EVENT = 8'h80;
    localparam logic [7:0] OFS_MASK = 8'h84;
    localparam logic [7:0] OFS_PRESENT = 8'h88;
    localparam logic [7:0] OFS_FORCE = 8'h8c;

    // field positions
    localparam int BIT_WAKE = 4;
    localparam int BIT_SUMMARY = 14;
    localparam int BIT_INT = 15;
    localparam int LANE_WAKE = 0;
    localparam int LANE_HIGH = 1;

    // values after reset
    localparam logic RST_BIT = 1'b0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // pin input synchroniser depth
    localparam int SYNC_STAGES = 3;

endpackage

//--- core/pin_event_sync.sv
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser for an asynchronous level; the filtered
// level only moves once the second and third stages agree
module pin_event_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_async,
    output logic rise_pulse
);
    import cardbus_status_pkg::*;

    logic [SYNC_STAGES-1:0] stage_reg;
    logic [SYNC_STAGES-1:0] stage_next;
    logic level_reg;
    logic level_next;
    logic rise_next;

    always_comb begin
        stage_next = {stage_reg[SYNC_STAGES-2:0], pin_async};
        level_next = level_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            level_next = stage_reg[2];
        end
        rise_next = level_next & ~level_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_reg <= '0;
            level_reg <= RST_BIT;
            rise_pulse <= RST_BIT;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
            rise_pulse <= rise_next;
        end
    end

endmodule

`default_nettype wire

//--- verification/cardbus_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// host software side: memory and I/O cycles plus the config-space enable
module cardbus_host_model (
    input wire logic clk,
    output logic req_valid,
    output logic req_mem_space,
    output logic req_write,
    output logic [cardbus_status_pkg::ADDR_W-1:0] req_addr,
    output logic [cardbus_status_pkg::DATA_W-1:0] req_wdata,
    output logic [3:0] req_byte_en,
    output logic pm_event_enable_flag,
    input wire logic rsp_valid,
    input wire logic rsp_claim,
    input wire logic [cardbus_status_pkg::DATA_W-1:0] rsp_rdata
);
    import cardbus_status_pkg::*;

    // byte lanes for the next access; the bench narrows it to test gating
    logic [3:0] lanes = 4'hf;

    initial begin
        req_valid = 1'b0;
        req_mem_space = 1'b0;
        req_write = 1'b0;
        req_addr = 8'h00;
        req_wdata = 32'h0000_0000;
        req_byte_en = 4'h0;
        pm_event_enable_flag = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // entered just after an edge; returns just after the answer is sampled
    task automatic access(input logic mem, input logic wr,
                          input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d,
                          output logic ok, output logic [DATA_W-1:0] q);
        req_valid = 1'b1;
        req_mem_space = mem;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_byte_en = lanes;
        @(posedge clk);
        #1;
        // released lines carry the inverse so stale values never look valid
        req_valid = 1'b0;
        req_addr = ~a;
        req_wdata = ~d;
        req_byte_en = 4'h0;
        // the answer stands only from the taking edge to the next one
        @(posedge clk);
        ok = rsp_valid & rsp_claim;
        q = rsp_rdata;
        #1;
    endtask

    // clearing this flag also stops the status-change pin, as clearing mask bit 4 or 14 does
    task automatic set_enable(input logic en);
        pm_event_enable_flag = en;
    endtask
endmodule

`default_nettype wire

//--- verification/cardbus_status_change_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module cardbus_status_change_regs_tb;
    import cardbus_status_pkg::*;

    logic clk = 1'b0;
    logic rst, hw, sw, det, pms, fip, wpin, ok;
    logic rv, rm, rw, en, sv, sc, scp, ip;
    logic [ADDR_W-1:0] ra;
    logic [DATA_W-1:0] wd, rq, q;
    logic [3:0] be;
    int num_errors = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    cardbus_status_change_regs dut (.clk(clk), .rst(rst),
        .hw_reset_req(hw), .sw_reset_req(sw), .req_valid(rv),
        .req_mem_space(rm), .req_write(rw), .req_addr(ra),
        .req_wdata(wd), .req_byte_en(be), .rsp_valid(sv),
        .rsp_claim(sc), .rsp_rdata(rq), .wake_event_pin(wpin),
        .pm_event_detect(det), .pm_event_status_flag(pms),
        .pm_event_enable_flag(en), .func_int_pending(fip),
        .status_change_pin(scp), .int_pin(ip));

    cardbus_host_model host (.clk(clk), .req_valid(rv),
        .req_mem_space(rm), .req_write(rw), .req_addr(ra),
        .req_wdata(wd), .req_byte_en(be), .pm_event_enable_flag(en),
        .rsp_valid(sv), .rsp_claim(sc), .rsp_rdata(rq));

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // reserved bits may read anything, so only bits 15, 14 and 4 count
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        host.access(1'b1, 1'b0, a, 32'h0000_0000, ok, q);
        chk(q & 32'h0000_c010, e);
    endtask

    task automatic wr(input logic m, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
        host.access(m, 1'b1, a, d, ok, q);
    endtask

    task automatic pin(input logic got, input logic exp);
        chk({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc(OFS_EVENT, 32'h0000_0000);
        rdc(OFS_MASK, 32'h0000_0000);
        rdc(OFS_PRESENT, 32'h0000_0000);
        pin(scp | ip, 1'b0);
    endtask

    task automatic t_space;
        wr(1'b0, OFS_MASK, 32'h0000_c010);
        pin(ok, 1'b0);
        rdc(OFS_MASK, 32'h0000_0000);
        wr(1'b1, 8'h90, 32'h0000_c010);
        pin(ok, 1'b0);
        wr(1'b1, OFS_MASK, 32'h0000_c010);
        pin(ok, 1'b1);
        rdc(OFS_MASK, 32'h0000_c010);
        host.lanes = 4'h2;
        wr(1'b1, OFS_MASK, 32'h0000_0000);
        host.lanes = 4'hf;
        rdc(OFS_MASK, 32'h0000_0010);
        wr(1'b1, OFS_MASK, 32'h0000_c010);
    endtask

    task automatic t_wake;
        host.set_enable(1'b1);
        det = 1'b1;
        cyc(1);
        det = 1'b0;
        rdc(OFS_EVENT, 32'h0000_0010);
        rdc(OFS_PRESENT, 32'h0000_0010);
        pin(scp, 1'b1);
        wr(1'b1, OFS_MASK, 32'h0000_8010);
        cyc(1);
        pin(scp, 1'b0);
        wr(1'b1, OFS_MASK, 32'h0000_c010);
        host.set_enable(1'b0);
        cyc(2);
        pin(scp, 1'b0);
        host.set_enable(1'b1);
        wr(1'b1, OFS_EVENT, 32'h0000_0010);
        rdc(OFS_EVENT, 32'h0000_0000);
        rdc(OFS_PRESENT, 32'h0000_0000);
        pin(scp, 1'b0);
    endtask

    task automatic t_pmclear;
        pms = 1'b1;
        wpin = 1'b1;
        cyc(10);
        rdc(OFS_EVENT, 32'h0000_0010);
        pms = 1'b0;
        wpin = 1'b0;
        cyc(1);
        rdc(OFS_EVENT, 32'h0000_0000);
        rdc(OFS_PRESENT, 32'h0000_0000);
    endtask

    task automatic t_int;
        fip = 1'b1;
        cyc(2);
        rdc(OFS_EVENT, 32'h0000_8000);
        rdc(OFS_PRESENT, 32'h0000_8000);
        pin(ip, 1'b1);
        fip = 1'b0;
        cyc(1);
        rdc(OFS_PRESENT, 32'h0000_0000);
        wr(1'b1, OFS_EVENT, 32'h0000_8000);
        rdc(OFS_EVENT, 32'h0000_0000);
        pin(ip, 1'b0);
    endtask

    task automatic t_force;
        wr(1'b1, OFS_FORCE, 32'h0000_0000);
        rdc(OFS_EVENT, 32'h0000_0000);
        wr(1'b1, OFS_FORCE, 32'h0000_8010);
        rdc(OFS_EVENT, 32'h0000_8010);
        rdc(OFS_PRESENT, 32'h0000_0000);
        wr(1'b1, OFS_MASK, 32'h0000_4010);
        cyc(1);
        pin(ip, 1'b0);
        wr(1'b1, OFS_MASK, 32'h0000_c010);
        cyc(1);
        pin(ip, 1'b1);
    endtask

    task automatic t_reset_kinds;
        for (int i = 0; i < 2; i++) begin
            wr(1'b1, OFS_FORCE, 32'h0000_8010);
            hw = (i == 0);
            sw = (i == 1);
            cyc(1);
            hw = 1'b0;
            sw = 1'b0;
            rdc(OFS_EVENT, 32'h0000_0010);
            rdc(OFS_MASK, 32'h0000_4010);
            rdc(OFS_PRESENT, 32'h0000_0000);
            wr(1'b1, OFS_MASK, 32'h0000_c010);
        end
        rst = 1'b1;
        cyc(1);
        rst = 1'b0;
        rdc(OFS_EVENT, 32'h0000_0000);
        rdc(OFS_MASK, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // the whole sequence needs about 120 cycles; allow about forty times that
    initial begin
        #250000;
        num_errors++;
        finish_test;
    end

    initial begin
        rst = 1'b1;
        hw = 1'b0;
        sw = 1'b0;
        det = 1'b0;
        pms = 1'b0;
        fip = 1'b0;
        wpin = 1'b0;
        cyc(6);
        rst = 1'b0;
        t_reset;
        t_space;
        t_wake;
        t_pmclear;
        t_int;
        t_force;
        t_reset_kinds;
        finish_test;
    end
endmodule

`default_nettype wire
